//--- abqd_pkg.sv
// package for the adapter bus quarter demultiplexer
// assumes a 40 MHz system clock sampling the slow adapter bus clocks
package abqd_pkg;

  // ----------------------------------------------------------------
  // bus field layout
  // ----------------------------------------------------------------
  localparam int ABQD_BYTE_W      = 8;
  localparam int ABQD_ADDR_W      = 15;
  localparam int ABQD_EXT_W       = 5;
  localparam int ABQD_STAT_RXDATA = 6;   // status bit: received frame data
  localparam int ABQD_STAT_RXNEW  = 7;   // status bit: first word of new frame

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  ABQD_BYTE_RST = 8'h00;
  localparam logic [14:0] ABQD_ADDR_RST = 15'h0000;
  localparam logic [4:0]  ABQD_EXT_RST  = 5'h00;
  localparam logic [1:0]  ABQD_SYNC_RST = 2'h0;

  // ----------------------------------------------------------------
  // quarter tracker, gray coded along 1Q-2Q-3Q-4Q
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ABQD_Q1 = 2'h0,
    ABQD_Q2 = 2'h1,
    ABQD_Q3 = 2'h3,
    ABQD_Q4 = 2'h2
  } abqd_quarter_type;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] high_byte_mux_lines;
    logic [7:0] low_byte_mux_lines;
    logic       high_ext_addr_parity_line;
    logic       low_ext_addr_parity_line;
  } abqd_bus_type;

  typedef struct packed {
    logic [4:0]  extended_address_bits;
    logic [14:0] address;
  } abqd_addr_type;

  typedef struct packed {
    logic [7:0] status;
    logic       rx_data_word;
    logic       rx_new_frame;
  } abqd_stat_type;

  typedef struct packed {
    logic [15:0] data;
    logic        parity_high;
    logic        parity_low;
    logic        write;
  } abqd_data_type;

  typedef struct packed {
    logic [1:0]       lead_sync;
    logic [1:0]       lag_sync;
    logic [1:0]       rst_sync;
    logic [1:0]       en_sync;
    logic [1:0]       dir_sync;
    abqd_bus_type     bus_s1;
    abqd_bus_type     bus_s2;
    logic             lead_prev;
    logic             lag_prev;
    abqd_quarter_type quarter;
    abqd_addr_type    addr;
    abqd_stat_type    stat;
    abqd_data_type    data;
    logic             addr_valid;
    logic             stat_valid;
    logic             data_valid;
  } abqd_state_type;

endpackage

//--- abqd_demux.sv
// adapter bus quarter demultiplexer: snoops a time-multiplexed memory bus
// assumes bus pins are asynchronous to clk_in and the bus clocks run far below 40 MHz
//
// Summary of operation
// - high byte first quarter: AX4 then A0-A6
// - high byte second quarter carries status bits
// - high byte last half: data bits 0-7
// - high byte line zero is msb
// - low byte first quarter: A7-A14
// - low byte second quarter repeats AX4, A0-A6
// - low byte last half: data bits 8-15
// - low byte line zero is msb
// - high ext line: AX1 then AX0
// - high ext line last half: high parity
// - low ext line: AX3 then AX2
// - low ext line last half: low parity
`timescale 1ns/1ps

module abqd_demux
  import abqd_pkg::*;
(
  // system
  input  wire logic                  clk_in,
  input  wire logic                  reset_n_in,
  // adapter bus pins, all driven by the bus master
  input  wire abqd_pkg::abqd_bus_type bus_in,
  input  wire logic                  bus_clock_lead_in,
  input  wire logic                  bus_clock_lag_in,
  input  wire logic                  buffer_enable_n_in,
  input  wire logic                  transfer_direction_in,
  input  wire logic                  memory_bus_reset_n_in,
  // captured address
  output logic                       addr_valid_out,
  output abqd_pkg::abqd_addr_type    addr_out,
  // captured status
  output logic                       stat_valid_out,
  output abqd_pkg::abqd_stat_type    stat_out,
  // captured data
  output logic                       data_valid_out,
  output abqd_pkg::abqd_data_type    data_out,
  output logic                       parity_ok_out
);
  import abqd_pkg::*;

  abqd_state_type st_ff;
  abqd_state_type nxt_st;

  logic lead_rise;
  logic lead_fall;
  logic lag_rise;
  logic lag_fall;
  logic bus_rst_n;

  // ----------------------------------------------------------------
  // edge detection on the second synchroniser stage only
  // ----------------------------------------------------------------
  // lag trails lead by a quarter clock, so the four edges split a bus
  // clock into four; one memory cycle is two bus clocks
  assign lead_rise = st_ff.lead_sync[1] & ~st_ff.lead_prev;
  assign lead_fall = ~st_ff.lead_sync[1] & st_ff.lead_prev;
  assign lag_rise  = st_ff.lag_sync[1] & ~st_ff.lag_prev;
  assign lag_fall  = ~st_ff.lag_sync[1] & st_ff.lag_prev;
  assign bus_rst_n = st_ff.rst_sync[1];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  // a quarter is closed by the lag-clock edge in its middle so the
  // sampled bus (bus_s2) has settled; the lead edge opens the next one
  always_comb begin
    nxt_st = st_ff;
    nxt_st.lead_sync = {st_ff.lead_sync[0], bus_clock_lead_in};
    nxt_st.lag_sync  = {st_ff.lag_sync[0], bus_clock_lag_in};
    nxt_st.rst_sync  = {st_ff.rst_sync[0], memory_bus_reset_n_in};
    nxt_st.en_sync   = {st_ff.en_sync[0], buffer_enable_n_in};
    nxt_st.dir_sync  = {st_ff.dir_sync[0], transfer_direction_in};
    nxt_st.bus_s1    = bus_in;
    nxt_st.bus_s2    = st_ff.bus_s1;
    nxt_st.lead_prev = st_ff.lead_sync[1];
    nxt_st.lag_prev  = st_ff.lag_sync[1];
    nxt_st.addr_valid = 1'b0;
    nxt_st.stat_valid = 1'b0;
    nxt_st.data_valid = 1'b0;
    // quarter tracking: lead rising starts 1Q and 3Q alternately; the
    // bus enable is not used here, since a cycle without data phase
    // still runs through 3Q and 4Q and must not be taken as an address
    if (lead_rise) begin
      nxt_st.quarter = (st_ff.quarter == ABQD_Q2) ? ABQD_Q3 : ABQD_Q1;
    end else if (lead_fall) begin
      case (st_ff.quarter)
        ABQD_Q1: nxt_st.quarter = ABQD_Q2;
        ABQD_Q3: nxt_st.quarter = ABQD_Q4;
        default: nxt_st.quarter = st_ff.quarter;
      endcase
    end
    // quarter one: address, lines read msb first on line zero
    if (lag_rise && st_ff.quarter == ABQD_Q1) begin
      nxt_st.addr.extended_address_bits[4] = st_ff.bus_s2.high_byte_mux_lines[7];
      for (int i = 0; i < 7; i++) begin
        nxt_st.addr.address[i] = st_ff.bus_s2.high_byte_mux_lines[6 - i];
      end
      for (int i = 0; i < ABQD_BYTE_W; i++) begin
        nxt_st.addr.address[7 + i] = st_ff.bus_s2.low_byte_mux_lines[7 - i];
      end
      nxt_st.addr.extended_address_bits[1] = st_ff.bus_s2.high_ext_addr_parity_line;
      nxt_st.addr.extended_address_bits[3] = st_ff.bus_s2.low_ext_addr_parity_line;
    end
    // quarter two: status, plus AX0 and AX2; AX4 in the low byte repeat is a cross check
    if (lag_fall && st_ff.quarter == ABQD_Q2) begin
      nxt_st.stat.status = st_ff.bus_s2.high_byte_mux_lines;
      nxt_st.stat.rx_data_word =
        st_ff.bus_s2.high_byte_mux_lines[7 - ABQD_STAT_RXDATA];
      nxt_st.stat.rx_new_frame =
        st_ff.bus_s2.high_byte_mux_lines[7 - ABQD_STAT_RXNEW];
      nxt_st.addr.extended_address_bits[0] = st_ff.bus_s2.high_ext_addr_parity_line;
      nxt_st.addr.extended_address_bits[2] = st_ff.bus_s2.low_ext_addr_parity_line;
      if (st_ff.bus_s2.low_byte_mux_lines[7] == st_ff.addr.extended_address_bits[4]) begin
        nxt_st.addr_valid = 1'b1;
      end
      nxt_st.stat_valid = 1'b1;
    end
    // last half: data captured by the lag edge inside quarter four while
    // buffers are enabled; that edge is a falling one, as in quarter two
    if (lag_fall && st_ff.quarter == ABQD_Q4 && !st_ff.en_sync[1]) begin
      for (int i = 0; i < ABQD_BYTE_W; i++) begin
        nxt_st.data.data[i]     = st_ff.bus_s2.high_byte_mux_lines[7 - i];
        nxt_st.data.data[8 + i] = st_ff.bus_s2.low_byte_mux_lines[7 - i];
      end
      nxt_st.data.parity_high = st_ff.bus_s2.high_ext_addr_parity_line;
      nxt_st.data.parity_low  = st_ff.bus_s2.low_ext_addr_parity_line;
      nxt_st.data.write       = st_ff.dir_sync[1];
      nxt_st.data_valid       = 1'b1;
    end
    // bus reset from the master clears holding registers like a local reset
    if (!bus_rst_n) begin
      nxt_st.quarter = ABQD_Q1;
      nxt_st.addr    = '{extended_address_bits: ABQD_EXT_RST, address: ABQD_ADDR_RST};
      nxt_st.stat    = '{status: ABQD_BYTE_RST, rx_data_word: 1'b0, rx_new_frame: 1'b0};
      nxt_st.data    = '{data: {ABQD_BYTE_RST, ABQD_BYTE_RST}, parity_high: 1'b0,
                         parity_low: 1'b0, write: 1'b0};
      nxt_st.addr_valid = 1'b0;
      nxt_st.stat_valid = 1'b0;
      nxt_st.data_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      st_ff <= '0;
      st_ff.rst_sync <= ABQD_SYNC_RST;
      st_ff.quarter  <= ABQD_Q1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // parity sense is not fixed by the bus, so odd parity is reported only
  assign addr_valid_out = st_ff.addr_valid;
  assign addr_out       = st_ff.addr;
  assign stat_valid_out = st_ff.stat_valid;
  assign stat_out       = st_ff.stat;
  assign data_valid_out = st_ff.data_valid;
  assign data_out       = st_ff.data;
  assign parity_ok_out  = (^{st_ff.data.data[7:0], st_ff.data.parity_high}) &
                          (^{st_ff.data.data[15:8], st_ff.data.parity_low});

endmodule

//--- abqd_master_model.sv
// bus master model: drives one multiplexed memory cycle per call
// assumes a 1 ns unit; bus clocks stand still between cycles
`timescale 1ns/1ps
module abqd_master_model (
  // adapter bus pins
  output abqd_pkg::abqd_bus_type bus_out,
  output logic                   lead_out,
  output logic                   lag_out,
  output logic                   en_n_out,
  output logic                   dir_out
);
  import abqd_pkg::*;
  initial begin
    bus_out = '0;
    {lead_out, lag_out, dir_out} = 3'h0;
    en_n_out = 1'h1;
  end
  // quarters of 100 ns; data held past the last lag edge so late samplers still see it
  task automatic run_cycle(input abqd_addr_type a, input logic [7:0] st,
                           input logic [15:0] d, input logic wr, input logic en);
    logic [7:0] hq;
    logic [7:0] lq;
    logic [4:0] x;
    x = a.extended_address_bits;
    hq[7] = x[4];
    for (int i = 0; i < 8; i++) begin
      lq[7-i] = a.address[7+i];
      if (i < 7) hq[6-i] = a.address[i];
    end
    #7 dir_out = wr;
    bus_out = {hq, lq, x[1], x[3]};
    lead_out = 1'h1;
    #50 lag_out = 1'h1;
    #50 lead_out = 1'h0;
    bus_out = {st, hq, x[0], x[2]};
    #50 lag_out = 1'h0;
    #25 en_n_out = ~en;
    #25 lead_out = 1'h1;
    bus_out = {{<<{d[7:0]}}, {<<{d[15:8]}}, ~^d[7:0], ~^d[15:8]};
    #50 lag_out = 1'h1;
    #50 lead_out = 1'h0;
    #50 lag_out = 1'h0;
    #75 en_n_out = 1'h1;
    // released lines must not keep showing the last value
    bus_out = ~bus_out;
    dir_out = ~wr;
    #100;
  endtask
endmodule

//--- abqd_demux_sva.sv
// checker for the quarter demultiplexer outputs
// assumes the 40 MHz clock and its synchronous reset
`timescale 1ns/1ps
module abqd_demux_sva (
  // watched ports
  input wire logic                    clk_in,
  input wire logic                    reset_n_in,
  input wire logic                    buffer_enable_n_in,
  input wire logic                    addr_valid_out,
  input wire abqd_pkg::abqd_addr_type addr_out,
  input wire logic                    stat_valid_out,
  input wire abqd_pkg::abqd_stat_type stat_out,
  input wire logic                    data_valid_out,
  input wire abqd_pkg::abqd_data_type data_out,
  input wire logic                    parity_ok_out
);
  import abqd_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  logic [3:0] since_en_ff;
  // cycles since the buffer enable was last seen low, saturating
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !buffer_enable_n_in) since_en_ff <= 4'hF * !reset_n_in;
    else if (since_en_ff != 4'hF) since_en_ff <= since_en_ff + 4'h1;
  end
  addr_with_stat_a: assert property (addr_valid_out |-> stat_valid_out)
    else $error("address capture without status capture");
  addr_pulse_a: assert property (addr_valid_out |=> !addr_valid_out)
    else $error("address valid longer than one cycle");
  stat_pulse_a: assert property (stat_valid_out |=> !stat_valid_out)
    else $error("status valid longer than one cycle");
  data_after_stat_a: assert property (stat_valid_out |=> !data_valid_out [*3])
    else $error("data capture too soon after status");
  rx_flags_a: assert property (stat_valid_out |-> stat_out.rx_data_word == stat_out.status[1]
    && stat_out.rx_new_frame == stat_out.status[0]) else $error("receive flags wrong");
  data_enable_a: assert property (data_valid_out |-> since_en_ff < 4'h8)
    else $error("data captured without buffer enable");
  data_hold_a: assert property ($changed(data_out) |-> data_valid_out || data_out == '0)
    else $error("data changed without capture");
  addr_hold_a: assert property ($changed(addr_out) |-> addr_out == '0 or ##[0:8] stat_valid_out)
    else $error("address changed without capture");
  parity_a: assert property (parity_ok_out == (^{data_out.data[7:0], data_out.parity_high}
    && ^{data_out.data[15:8], data_out.parity_low})) else $error("parity flag wrong");
endmodule
bind abqd_demux abqd_demux_sva abqd_demux_sva_inst (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .buffer_enable_n_in(buffer_enable_n_in), .addr_valid_out(addr_valid_out),
  .addr_out(addr_out), .stat_valid_out(stat_valid_out), .stat_out(stat_out),
  .data_valid_out(data_valid_out), .data_out(data_out), .parity_ok_out(parity_ok_out));

//--- abqd_demux_tb_top.sv
// bench for the quarter demultiplexer, bus master modelled separately
// assumes capture pulses settle within four clocks after a cycle ends
`timescale 1ns/1ps
module abqd_demux_tb_top;
  import abqd_pkg::*;
  logic          clk_in = 1'h0;
  logic          reset_n_in = 1'h0;
  logic          mrst_n = 1'h1;
  abqd_bus_type  bus;
  logic          lead, lag, en_n, dir, a_v, s_v, d_v, p_ok;
  abqd_addr_type addr;
  abqd_stat_type stat;
  abqd_data_type data;
  int            mismatches = 0, checks = 0, cycles = 0, n_a = 0, n_s = 0, n_d = 0;
  always #12.5 clk_in = ~clk_in;
  abqd_master_model abqd_master_model_inst (.bus_out(bus), .lead_out(lead), .lag_out(lag),
    .en_n_out(en_n), .dir_out(dir));
  abqd_demux abqd_demux_inst (.clk_in(clk_in), .reset_n_in(reset_n_in), .bus_in(bus),
    .bus_clock_lead_in(lead), .bus_clock_lag_in(lag), .buffer_enable_n_in(en_n),
    .transfer_direction_in(dir), .memory_bus_reset_n_in(mrst_n), .addr_valid_out(a_v),
    .addr_out(addr), .stat_valid_out(s_v), .stat_out(stat), .data_valid_out(d_v),
    .data_out(data), .parity_ok_out(p_ok));
  // pulse tallies and the hang limit; a run needs well under 2000 clocks
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    n_a <= n_a + a_v;
    n_s <= n_s + s_v;
    n_d <= n_d + d_v;
    if (cycles == 2000) begin
      mismatches = mismatches + 1;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one memory cycle, then count the capture pulses it caused
  task automatic cyc(input abqd_addr_type a, input logic [7:0] st, input logic [15:0] d,
                     input logic wr, input logic en);
    int na, ns, nd;
    {na, ns, nd} = {n_a, n_s, n_d};
    abqd_master_model_inst.run_cycle(a, st, d, wr, en);
    repeat (4) @(posedge clk_in);
    chk(n_s - ns, 1);
    chk(n_a - na, 1);
    chk(n_d - nd, en);
  endtask
  task automatic t_write;
    cyc({5'h15, 15'h4D2B}, 8'h03, 16'hA5C3, 1'h1, 1'h1);
    chk(addr, {5'h15, 15'h4D2B});
    chk(stat, {8'h03, 2'h3});
    chk(data, {16'hA5C3, 3'h7});
    chk(p_ok, 1'h1);
  endtask
  task automatic t_read;
    cyc({5'h0A, 15'h0001}, 8'h40, 16'h0180, 1'h0, 1'h1);
    chk(addr, {5'h0A, 15'h0001});
    chk(stat, {8'h40, 2'h0});
    chk(data, {16'h0180, 3'h0});
  endtask
  task automatic t_no_enable;
    cyc({5'h1F, 15'h4000}, 8'h02, 16'hFFFF, 1'h1, 1'h0);
    chk(addr, {5'h1F, 15'h4000});
    chk(stat, {8'h02, 2'h2});
    chk(data, {16'h0180, 3'h0});
  endtask
  task automatic t_mem_reset;
    mrst_n <= 1'h0;
    repeat (6) @(posedge clk_in);
    chk(addr, 32'h0);
    chk(data, 32'h0);
    mrst_n <= 1'h1;
    repeat (4) @(posedge clk_in);
  endtask
  task automatic end_of_test;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_in);
    reset_n_in <= 1'h1;
    repeat (6) @(posedge clk_in);
    t_write();
    t_read();
    t_no_enable();
    t_mem_reset();
    end_of_test();
  end
endmodule
